/* File: dv/ebm_bus_test.sv */
// Self-checking bench for ebm_bus with an external memory partner.
// Assumes the package defaults for the memory map and DRAM window.
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
    mismatches++; \
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module ebm_bus_test;
    logic                      clk       = 1'b0;
    logic                      resetn    = 1'b0;
    ebm_pkg::ebm_strobe_mode_t mode      = ebm_pkg::EBM_SEPARATE;
    logic                      vb_we     = 1'b0;
    logic [23:0]               vb_in     = 24'h000000;
    logic [23:0]               vb_out;
    logic                      req_valid = 1'b0;
    logic                      req_ready;
    ebm_pkg::ebm_req_t         req       = '0;
    ebm_pkg::ebm_region_t      region;
    logic                      rsp_valid;
    logic [15:0]               rsp_data;
    logic                      hold_n    = 1'b1;
    logic                      wait_n;
    logic [15:0]               din;
    ebm_pkg::ebm_pins_t        pins;
    logic [1:0]                slow      = 2'h0;
    int                        mismatches  = 0;
    int                        comparisons = 0;
    int                        cycles      = 0;
    logic [6:0]                seen;
    logic [3:0]                sel_seen;
    logic                      ale_seen;
    logic [7:0]                row_mux;
    logic [7:0]                col_mux;

    always #2.5 clk = ~clk;

    ebm_bus u_ebm_bus (.CLK(clk), .RESETN(resetn), .STROBE_MODE(mode),
        .VECTOR_BASE_WE(vb_we), .VECTOR_BASE_IN(vb_in),
        .VECTOR_TABLE_BASE(vb_out), .REQ_VALID(req_valid),
        .REQ_READY(req_ready), .REQ(req), .REGION(region),
        .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .HOLD_REQ_N(hold_n),
        .WAIT_REQ_N(wait_n), .DATA_IN(din), .BUS_PINS(pins));

    ebm_mem_model u_ebm_mem_model (.clk(clk), .pins(pins),
        .common(mode == ebm_pkg::EBM_COMMON), .slow(slow), .data(din),
        .wait_n(wait_n));

    task automatic finish_test();
        $display("Comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test

    // Strobe history of one access; a zero bit means it went low
    always @(posedge clk) begin
        cycles++;
        seen <= seen & {pins.low_byte_write_strobe_n,
            pins.high_byte_write_strobe_n, pins.read_strobe_n,
            pins.dram_row_strobe_n, pins.column_strobe_even_n,
            pins.column_strobe_odd_n, pins.dram_write_strobe_n};
        sel_seen <= sel_seen & pins.space_select_lines_n;
        ale_seen <= ale_seen | pins.addr_latch;
        if (!pins.dram_row_strobe_n && pins.column_strobe_even_n &&
            pins.column_strobe_odd_n)
            row_mux <= pins.dram_mux_address;
        if (!pins.column_strobe_even_n || !pins.column_strobe_odd_n)
            col_mux <= pins.dram_mux_address;
        if (cycles == 5000) begin
            mismatches++;
            finish_test();
        end
    end

    // One bus access, returns read data and cycles to the answer
    task automatic access(input logic [23:0] ad, input logic [15:0] wd,
                          input logic wr, input logic wo,
                          output logic [15:0] rd, output int cyc);
        int k;
        k = 0;
        while (req_ready !== 1'b1 && k < 50) begin
            @(negedge clk);
            k++;
        end
        seen = 7'h7F;
        sel_seen = 4'hF;
        ale_seen = 1'b0;
        @(posedge clk);
        req_valid <= 1'b1;
        req <= '{addr: ad, wdata: wd, write: wr, word: wo};
        @(posedge clk);
        req_valid <= 1'b0;
        cyc = 0;
        do begin
            @(negedge clk);
            cyc++;
        end while (rsp_valid !== 1'b1 && cyc < 40);
        `CHK(rsp_valid, 1'b1)
        rd = rsp_data;
    endtask : access

    // Decode of one address into one region flag
    task automatic chk_region(input logic [23:0] ad, input int b,
                              input logic e);
        @(posedge clk);
        req.addr <= ad;
        @(negedge clk);
        `CHK(region[b], e)
    endtask : chk_region

    task automatic s_hold();
        @(posedge clk);
        hold_n <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        `CHK(pins.bus_grant_out_n, 1'b0)
        `CHK(pins.addr_oe_n, 1'b1)
        `CHK(req_ready, 1'b0)
        @(posedge clk);
        hold_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        `CHK(pins.bus_grant_out_n, 1'b1)
    endtask : s_hold

    initial begin
        logic [15:0] d;
        int          c0;
        int          c2;
        repeat (6) @(posedge clk);
        `CHK(pins.addr_high, 8'h80)
        `CHK(pins.addr_latch, 1'b0)
        resetn <= 1'b1;
        // Split strobes: word, odd byte, read back
        access(24'h800010, 16'hA55A, 1'b1, 1'b1, d, c0);
        `CHK(seen[6:5], 2'b00)
        `CHK(sel_seen, 4'b1011)
        `CHK(ale_seen, 1'b1)
        access(24'h800013, 16'h3C3C, 1'b1, 1'b0, d, c0);
        `CHK(seen[6:5], 2'b10)
        access(24'h800010, 16'h0000, 1'b0, 1'b1, d, c0);
        `CHK(d, 16'hA55A)
        `CHK(seen[4], 1'b0)
        // Common strobe with upper byte enable
        @(posedge clk);
        mode <= ebm_pkg::EBM_COMMON;
        access(24'h800010, 16'h0000, 1'b0, 1'b1, d, c0);
        `CHK(d, 16'hA55A)
        `CHK(seen[5], 1'b0)
        access(24'h800011, 16'h0069, 1'b1, 1'b0, d, c0);
        `CHK(seen[6:5], 2'b00)
        @(posedge clk);
        mode <= ebm_pkg::EBM_SEPARATE;
        access(24'h800011, 16'h0000, 1'b0, 1'b0, d, c0);
        `CHK(d[7:0], 8'h69)
        // Wait request stretches the strobe
        @(posedge clk);
        slow <= 2'h2;
        access(24'h800010, 16'h0000, 1'b0, 1'b1, d, c2);
        `CHK(c2 - c0, 2)
        @(posedge clk);
        slow <= 2'h0;
        // DRAM word write then odd byte read
        access(24'h412B46, 16'hBEEF, 1'b1, 1'b1, d, c0);
        `CHK(seen[3:0], 4'h0)
        `CHK(row_mux, 8'h95)
        `CHK(col_mux, 8'hA3)
        access(24'h412B47, 16'h0000, 1'b0, 1'b0, d, c0);
        `CHK(seen[2:0], 3'b101)
        // Internal RAM access: one cycle, no strobe or select activity
        access(24'h000400, 16'h1234, 1'b1, 1'b1, d, c0);
        `CHK(c0, 1)
        `CHK(seen, 7'h7F)
        `CHK(sel_seen, 4'hF)
        s_hold();
        // Memory map edges
        chk_region(24'h000000, 7, 1'b1);
        chk_region(24'h0003FF, 7, 1'b1);
        chk_region(24'h000400, 7, 1'b0);
        chk_region(24'h000400, 6, 1'b1);
        chk_region(24'hFE0000, 5, 1'b1);
        chk_region(24'hFDFFFF, 5, 1'b0);
        chk_region(24'hFFFFFF, 4, 1'b1);
        chk_region(24'hFFFFDC, 4, 1'b1);
        chk_region(24'hFFFFDB, 4, 1'b0);
        chk_region(24'hFFFFDB, 3, 1'b1);
        chk_region(24'hFFFE00, 3, 1'b1);
        chk_region(24'hFFFDFF, 3, 1'b0);
        chk_region(24'h400000, 1, 1'b1);
        chk_region(24'h3FFFFF, 1, 1'b0);
        chk_region(24'h002C00, 0, 1'b1);
        chk_region(24'h002BFF, 0, 1'b0);
        @(posedge clk);
        vb_we <= 1'b1;
        vb_in <= 24'h100000;
        @(posedge clk);
        vb_we <= 1'b0;
        @(negedge clk);
        `CHK(vb_out, 24'h100000)
        chk_region(24'h1000FF, 2, 1'b1);
        chk_region(24'h100100, 2, 1'b0);
        finish_test();
    end
endmodule : ebm_bus_test

/* File: dv/ebm_mem_model.sv */
// Partner model: 16-bit external memory of two byte lanes on the parallel bus.
// Assumes strobes come from registers and settle before the next CLK edge.
`timescale 1ns/100ps
module ebm_mem_model (
    input  wire logic               clk,
    input  wire ebm_pkg::ebm_pins_t pins,
    input  wire logic               common,
    input  wire logic [1:0]         slow,
    output      logic [15:0]        data,
    output      logic               wait_n
);
    logic [7:0]  mem [0:255];
    logic [15:0] last = 16'h5A5A;
    logic [2:0]  n    = 3'h0;
    logic [7:0]  a;
    logic        act;

    // A read, write or column strobe low means an access is in its strobe phase
    assign a   = pins.addr_low[7:0];
    assign act = !pins.low_byte_write_strobe_n || !pins.read_strobe_n
                 || (!common && !pins.high_byte_write_strobe_n)
                 || !pins.column_strobe_even_n || !pins.column_strobe_odd_n;

    assign wait_n = !(act && n >= 3'h1 && n <= {1'b0, slow});

    always @(posedge clk) begin
        n <= act ? n + 3'h1 : 3'h0;
        if (!pins.low_byte_write_strobe_n)
            mem[a] <= pins.data_out[7:0];
        if (!common && !pins.high_byte_write_strobe_n)
            mem[{a[7:1], 1'b1}] <= pins.data_out[15:8];
        if (!pins.read_strobe_n)
            last <= data;
    end

    // Released bus shows the inverse of the last driven value
    always_comb begin
        data = ~last;
        if (!pins.read_strobe_n)
            data = {mem[{a[7:1], 1'b1}],
                    common ? mem[a] : mem[{a[7:1], 1'b0}]};
    end
endmodule : ebm_mem_model

/* File: verilog/ebm_bus.sv */
// External bus controller: strobes, hold, wait, DRAM phases, address map.
// Assumes bus inputs synchronous to CLK and one request at a time.
`timescale 1ns/100ps
module ebm_bus #(
    parameter logic [23:0] RAM_BYTES  = ebm_pkg::RAM_BYTES_DEF,
    parameter logic [23:0] ROM_BYTES  = ebm_pkg::ROM_BYTES_DEF,
    parameter logic [23:0] VTAB_BYTES = ebm_pkg::VTAB_BYTES_DEF,
    parameter logic [23:0] DRAM_LO    = ebm_pkg::DRAM_LO_DEF,
    parameter logic [23:0] DRAM_HI    = ebm_pkg::DRAM_HI_DEF
) (
    input  wire logic                      CLK,
    input  wire logic                      RESETN,
    input  wire ebm_pkg::ebm_strobe_mode_t STROBE_MODE,
    input  wire logic                      VECTOR_BASE_WE,
    input  wire logic [23:0]               VECTOR_BASE_IN,
    output      logic [23:0]               VECTOR_TABLE_BASE,
    input  wire logic                      REQ_VALID,
    output      logic                      REQ_READY,
    input  wire ebm_pkg::ebm_req_t         REQ,
    output      ebm_pkg::ebm_region_t      REGION,
    output      logic                      RSP_VALID,
    output      logic [15:0]               RSP_DATA,
    input  wire logic                      HOLD_REQ_N,
    input  wire logic                      WAIT_REQ_N,
    input  wire logic [15:0]               DATA_IN,
    output      ebm_pkg::ebm_pins_t        BUS_PINS
);

    typedef struct packed {
        ebm_pkg::ebm_state_t              state;
        logic [ebm_pkg::CNT_W-1:0]        cnt;
        ebm_pkg::ebm_req_t                req;
        logic                             dram;
        logic                             second;
        logic [23:0]                      vbase;
        logic                             rsp;
        logic [15:0]                      rdata;
        ebm_pkg::ebm_pins_t               pins;
    } ebm_core_t;

    ebm_core_t s;
    ebm_core_t next_s;
    logic [23:0] a;
    logic        odd;
    logic        split;
    logic        common;

    // address decode over the request address
    assign a = REQ.addr;
    always_comb begin
        REGION.periph      = (a <= ebm_pkg::PERI_HI);
        REGION.ram         = (a >= ebm_pkg::RAM_LO) &&
                             (a < ebm_pkg::RAM_LO + RAM_BYTES);
        REGION.rom         = (a >= ebm_pkg::ADDR_TOP - ROM_BYTES + 24'h000001);
        REGION.fixed_vec   = (a >= ebm_pkg::FIXV_LO);
        REGION.special_vec = (a >= ebm_pkg::SPV_LO) && (a <= ebm_pkg::SPV_HI);
        REGION.reloc_vec   = (a >= s.vbase) && (a < s.vbase + VTAB_BYTES);
        REGION.dram        = (a >= DRAM_LO) && (a <= DRAM_HI);
        REGION.external    = !(REGION.periph || REGION.ram || REGION.rom);
    end

    assign REQ_READY         = (s.state == ebm_pkg::ST_IDLE) && HOLD_REQ_N;
    assign RSP_VALID         = s.rsp;
    assign RSP_DATA          = s.rdata;
    assign VECTOR_TABLE_BASE = s.vbase;
    assign BUS_PINS          = s.pins;
    assign common            = (STROBE_MODE == ebm_pkg::EBM_COMMON);
    assign odd               = s.req.addr[0];
    // Common scheme splits a non-DRAM word into two byte cycles on an 8-bit bus
    assign split             = common && s.req.word && !s.dram;

    // Next state and registered pin values
    always_comb begin
        next_s     = s;
        next_s.rsp = 1'b0;
        if (VECTOR_BASE_WE) begin
            next_s.vbase = VECTOR_BASE_IN;
        end
        case (s.state)
            ebm_pkg::ST_IDLE: begin
                // hold wins over a new request when idle
                if (!HOLD_REQ_N) begin
                    next_s.state = ebm_pkg::ST_HOLD;
                end else if (REQ_VALID) begin
                    next_s.req    = REQ;
                    next_s.dram   = REGION.dram;
                    next_s.second = 1'b0;
                    next_s.rdata  = 16'h0000;
                    next_s.cnt    = '0;
                    if (!REGION.external) begin
                        next_s.rsp = 1'b1; // Internal space: no strobe or select activity
                    end else if (REGION.dram) begin
                        next_s.state = ebm_pkg::ST_ROW;
                    end else begin
                        next_s.state = ebm_pkg::ST_ADDR;
                    end
                end
            end
            ebm_pkg::ST_ADDR: begin
                next_s.state = ebm_pkg::ST_STRB;
            end
            ebm_pkg::ST_ROW: begin
                next_s.cnt = s.cnt + 1'b1;
                // row phase lasts before the columns
                if (s.cnt == ebm_pkg::CNT_W'(ebm_pkg::ROW_CYC - 1)) begin
                    next_s.cnt   = '0;
                    next_s.state = ebm_pkg::ST_COL;
                end
            end
            ebm_pkg::ST_STRB, ebm_pkg::ST_COL: begin
                if (s.cnt != ebm_pkg::CNT_W'(ebm_pkg::STROBE_CYC - 1)) begin
                    next_s.cnt = s.cnt + 1'b1;
                // wait request holds the access open
                end else if (WAIT_REQ_N) begin
                    next_s.state = ebm_pkg::ST_END;
                    if (s.req.write) begin
                        next_s.rdata = s.rdata;
                    end else if (split) begin
                        if (s.second) begin
                            next_s.rdata[15:8] = DATA_IN[7:0];
                        end else begin
                            next_s.rdata[7:0] = DATA_IN[7:0];
                        end
                    end else if (s.req.word) begin
                        next_s.rdata = DATA_IN;
                    end else if (odd && !common) begin
                        next_s.rdata = {8'h00, DATA_IN[15:8]};
                    end else begin
                        next_s.rdata = {8'h00, DATA_IN[7:0]};
                    end
                end
            end
            ebm_pkg::ST_END: begin
                next_s.cnt = '0;
                // second byte cycle of a split word
                if (split && !s.second) begin
                    next_s.second      = 1'b1;
                    next_s.req.addr[0] = 1'b1;
                    next_s.state       = ebm_pkg::ST_ADDR;
                end else begin
                    next_s.rsp   = 1'b1;
                    next_s.state = ebm_pkg::ST_IDLE;
                end
            end
            ebm_pkg::ST_HOLD: begin
                if (HOLD_REQ_N) begin
                    next_s.state = ebm_pkg::ST_IDLE;
                end
            end
            default: begin
                next_s.state = ebm_pkg::ST_IDLE;
            end
        endcase

        // Pin values for the coming cycle, all strobes inactive by default
        next_s.pins = '1;
        next_s.pins.addr_latch = 1'b0;
        next_s.pins.data_out   = 16'h0000;
        next_s.pins.addr_oe_n  = 1'b0;
        // eight high bits, top bit inverted
        next_s.pins.addr_low   = next_s.req.addr[15:0];
        next_s.pins.addr_high  = next_s.req.addr[23:16];
        next_s.pins.addr_high[7] = ~next_s.req.addr[ebm_pkg::TOP_BIT];
        next_s.pins.dram_mux_address = next_s.req.addr[ebm_pkg::ROW_LSB +:
                                                       ebm_pkg::MUX_W];
        case (next_s.state)
            ebm_pkg::ST_HOLD: begin
                next_s.pins.addr_oe_n       = 1'b1;
                next_s.pins.bus_grant_out_n = 1'b0;
            end
            ebm_pkg::ST_ADDR, ebm_pkg::ST_STRB: begin
                // one select per quarter of the space
                next_s.pins.space_select_lines_n[
                    next_s.req.addr[ebm_pkg::CS_MSB:ebm_pkg::CS_LSB]] = 1'b0;
                // latch pulse in the address phase
                next_s.pins.addr_latch = (next_s.state == ebm_pkg::ST_ADDR);
            end
            ebm_pkg::ST_ROW, ebm_pkg::ST_COL: begin
                next_s.pins.dram_row_strobe_n = 1'b0;
            end
            default: begin
                next_s.pins.addr_oe_n = 1'b0;
            end
        endcase
        if (next_s.state == ebm_pkg::ST_STRB) begin
            if (!next_s.req.write) begin
                next_s.pins.read_strobe_n = 1'b0;
            end else if (common) begin
                // common write strobe, data on low lane
                next_s.pins.low_byte_write_strobe_n = 1'b0;
                next_s.pins.data_oe_n               = 1'b0;
                next_s.pins.data_out = {8'h00, next_s.second ?
                    next_s.req.wdata[15:8] : next_s.req.wdata[7:0]};
            end else begin
                next_s.pins.data_oe_n = 1'b0;
                next_s.pins.low_byte_write_strobe_n =
                    next_s.req.addr[0] && !next_s.req.word;
                next_s.pins.high_byte_write_strobe_n =
                    !next_s.req.addr[0] && !next_s.req.word;
                next_s.pins.data_out = next_s.req.word ? next_s.req.wdata :
                    {next_s.req.wdata[7:0], next_s.req.wdata[7:0]};
            end
            // upper byte enable marks odd access
            if (common) begin
                next_s.pins.high_byte_write_strobe_n = !next_s.req.addr[0];
            end
        end
        if (next_s.state == ebm_pkg::ST_COL) begin
            next_s.pins.dram_mux_address = next_s.req.addr[ebm_pkg::COL_LSB +:
                                                           ebm_pkg::MUX_W];
            next_s.pins.column_strobe_even_n =
                next_s.req.addr[0] && !next_s.req.word;
            next_s.pins.column_strobe_odd_n =
                !next_s.req.addr[0] && !next_s.req.word;
            // DRAM write strobe only for writes
            next_s.pins.dram_write_strobe_n = !next_s.req.write;
            next_s.pins.data_oe_n           = !next_s.req.write;
            next_s.pins.data_out            = next_s.req.wdata;
        end
    end

    // State register
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            s                        <= '0;
            s.pins                   <= '1;
            s.pins.addr_latch        <= 1'b0;
            s.pins.addr_low          <= 16'h0000;
            s.pins.addr_high         <= 8'h80;
            s.pins.data_out          <= 16'h0000;
            s.pins.dram_mux_address  <= 8'h00;
        end else begin
            s <= next_s;
        end
    end

    // Checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);

    property p_hold_grant;
        (s.state == ebm_pkg::ST_IDLE && !HOLD_REQ_N) |=>
            !s.pins.bus_grant_out_n && s.pins.addr_oe_n;
    endproperty
    a_hold_grant: assert property (p_hold_grant)
        else $error("hold request not granted");

    property p_grant_released;
        !s.pins.bus_grant_out_n |-> s.pins.data_oe_n &&
            s.pins.read_strobe_n && s.pins.dram_row_strobe_n;
    endproperty
    a_grant_released: assert property (p_grant_released)
        else $error("bus driven while granted");

    property p_wait_stall;
        (s.state inside {ebm_pkg::ST_STRB, ebm_pkg::ST_COL} && !WAIT_REQ_N)
            |=> !s.rsp && s.state != ebm_pkg::ST_END;
    endproperty
    a_wait_stall: assert property (p_wait_stall)
        else $error("access completed during wait");

    property p_sep_odd;
        (!common && !s.pins.data_oe_n && s.state == ebm_pkg::ST_STRB &&
         s.req.addr[0]) |-> !s.pins.high_byte_write_strobe_n &&
                            s.pins.low_byte_write_strobe_n;
    endproperty
    a_sep_odd: assert property (p_sep_odd)
        else $error("odd write used wrong strobe");

    property p_common_bhe;
        (common && s.state == ebm_pkg::ST_STRB) |->
            (s.pins.high_byte_write_strobe_n == !s.req.addr[0]);
    endproperty
    a_common_bhe: assert property (p_common_bhe)
        else $error("upper byte enable wrong");

    property p_ale_pulse;
        $rose(s.pins.addr_latch) |=>
            !s.pins.addr_latch && !s.pins.addr_oe_n;
    endproperty
    a_ale_pulse: assert property (p_ale_pulse)
        else $error("address latch not a single pulse");

    property p_dram_read;
        (s.state == ebm_pkg::ST_COL && !s.req.write) |->
            s.pins.dram_write_strobe_n;
    endproperty
    a_dram_read: assert property (p_dram_read)
        else $error("DRAM write strobe on read");

    property p_ras_first;
        $fell(s.pins.column_strobe_even_n & s.pins.column_strobe_odd_n) |->
            $past(!s.pins.dram_row_strobe_n, 2);
    endproperty
    a_ras_first: assert property (p_ras_first)
        else $error("column strobe before row phase");

    property p_top_inv;
        !s.pins.addr_oe_n |-> s.pins.addr_high[7] == !s.req.addr[23];
    endproperty
    a_top_inv: assert property (p_top_inv)
        else $error("top address bit not inverted");

    property p_read_width;
        $fell(s.pins.read_strobe_n) |-> !s.pins.read_strobe_n [*2];
    endproperty
    a_read_width: assert property (p_read_width)
        else $error("read strobe too short");

    property p_periph_map;
        REGION.periph |-> !REGION.ram && !REGION.external;
    endproperty
    a_periph_map: assert property (p_periph_map)
        else $error("register space overlaps");

    c_hold:  cover property (s.state == ebm_pkg::ST_HOLD);
    c_dram:  cover property (s.state == ebm_pkg::ST_COL && s.req.write);
    c_split: cover property (s.second && s.rsp);
    c_wait:  cover property (s.state == ebm_pkg::ST_STRB && !WAIT_REQ_N);

endmodule : ebm_bus

/* File: verilog/ebm_pkg.sv */
// External bus controller package: memory map, timing, carrier types.
// Assumes a 200 MHz system clock and a 24-bit flat address space.
package ebm_pkg;

    // Flat 24-bit address space bounds
    localparam int          ADDR_W   = 24;
    localparam logic [23:0] PERI_HI  = 24'h0003FF;
    localparam logic [23:0] RAM_LO   = 24'h000400;
    localparam logic [23:0] SPV_LO   = 24'hFFFE00;
    localparam logic [23:0] SPV_HI   = 24'hFFFFDB;
    localparam logic [23:0] FIXV_LO  = 24'hFFFFDC;
    localparam logic [23:0] ADDR_TOP = 24'hFFFFFF;

    // Default sizes of memories and the relocatable table
    localparam logic [23:0] RAM_BYTES_DEF  = 24'h002800;
    localparam logic [23:0] ROM_BYTES_DEF  = 24'h020000;
    localparam logic [23:0] VTAB_BYTES_DEF = 24'h000100;
    localparam logic [23:0] DRAM_LO_DEF    = 24'h400000;
    localparam logic [23:0] DRAM_HI_DEF    = 24'h7FFFFF;

    // Field positions on the pins
    localparam int TOP_BIT  = 23;
    localparam int CS_MSB   = 23;
    localparam int CS_LSB   = 22;
    localparam int ROW_LSB  = 9;
    localparam int COL_LSB  = 1;
    localparam int MUX_W    = 8;

    // Timing: figures in ns, counts derived from the clock period
    localparam int CLK_NS        = 5;
    localparam int STROBE_MIN_NS = 10;
    localparam int ROW_MIN_NS    = 10;
    localparam int STROBE_CYC    = (STROBE_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int ROW_CYC       = (ROW_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W         = 3;

    typedef enum logic { EBM_SEPARATE, EBM_COMMON } ebm_strobe_mode_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_STRB, ST_ROW, ST_COL, ST_END, ST_HOLD
    } ebm_state_t;

    typedef struct packed {
        logic [23:0] addr;
        logic [15:0] wdata;
        logic        write;
        logic        word;
    } ebm_req_t;

    typedef struct packed {
        logic periph;
        logic ram;
        logic rom;
        logic fixed_vec;
        logic special_vec;
        logic reloc_vec;
        logic dram;
        logic external;
    } ebm_region_t;

    typedef struct packed {
        logic [15:0] addr_low;
        logic [7:0]  addr_high;
        logic        addr_oe_n;
        logic [15:0] data_out;
        logic        data_oe_n;
        logic        low_byte_write_strobe_n;
        logic        high_byte_write_strobe_n;
        logic        read_strobe_n;
        logic        addr_latch;
        logic [3:0]  space_select_lines_n;
        logic        dram_row_strobe_n;
        logic        column_strobe_even_n;
        logic        column_strobe_odd_n;
        logic        dram_write_strobe_n;
        logic [7:0]  dram_mux_address;
        logic        bus_grant_out_n;
    } ebm_pins_t;

endpackage : ebm_pkg
